// ### hw/twoc_timer_wave.v
/*
 * Timer waveform output control: 8-bit counter, mode decode, double
 * buffered compare values, flags and two compare wave outputs, with an
 * AHB-Lite register slave. Assumes TICK_EN is a synchronous one-cycle
 * enable from a prescaler on CLK; pin direction is set by software.
 */
`include "twoc_consts.vh"
module twoc_timer_wave (
    input wire CLK,
    input wire RSTN,
    input wire TICK_EN,
    input wire HSEL,
    input wire [7:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output reg [31:0] HRDATA,
    output reg HREADYOUT,
    output reg HRESP,
    output reg WAVE_OUT_A,
    output reg WAVE_OUT_B,
    output reg WAVE_EN_A,
    output reg WAVE_EN_B
);
    reg [7:0] ctrl_a_r;
    reg sel_high_r;
    reg run_r;
    reg [7:0] count_r;
    reg [7:0] count_nxt;
    reg up_r;
    reg up_nxt;
    reg [7:0] cmp_a_buf_r;
    reg [7:0] cmp_b_buf_r;
    reg [7:0] cmp_a_r;
    reg [7:0] cmp_b_r;
    reg ovf_r;
    reg flag_a_r;
    reg flag_b_r;
    reg wr_pend_r;
    reg [7:0] wr_addr_r;
    reg cnt_written_r;
    reg [7:0] top;
    reg at_top;
    reg ovf_evt;
    wire [2:0] mode;
    wire is_pwm;
    wire is_dual;
    wire tick;
    wire match_a;
    wire match_b;
    wire wave_a;
    wire wave_b;
    wire con_a;
    wire con_b;
    wire addr_ok;
    wire wr;
    wire flag_wr;

    function is_pwm_mode;
        input [2:0] m;
        begin
            is_pwm_mode = (m == `TWOC_MODE_DUAL_FF) || (m == `TWOC_MODE_SINGLE_FF)
                || (m == `TWOC_MODE_DUAL_CA) || (m == `TWOC_MODE_SINGLE_CA);
        end
    endfunction

    assign mode = {sel_high_r, ctrl_a_r[1:0]};
    assign is_pwm = is_pwm_mode(mode);
    assign is_dual = (mode == `TWOC_MODE_DUAL_FF) || (mode == `TWOC_MODE_DUAL_CA);
    // the prescaler or async oscillator is outside; only its tick advances us
    assign tick = TICK_EN & run_r;
    // a counter write blocks the compare match on the next tick
    assign match_a = tick & (count_r == cmp_a_r) & ~cnt_written_r;
    assign match_b = tick & (count_r == cmp_b_r) & ~cnt_written_r;

    always @*
    begin
        case (mode)
            `TWOC_MODE_CLEAR: top = cmp_a_r;
            `TWOC_MODE_DUAL_CA: top = cmp_a_r;
            `TWOC_MODE_SINGLE_CA: top = cmp_a_r;
            default: top = `TWOC_MAX;
        endcase
    end

    always @*
    begin
        count_nxt = count_r;
        up_nxt = up_r;
        at_top = 1'b0;
        ovf_evt = 1'b0;
        if (tick)
        begin
            case (mode)
                `TWOC_MODE_CLEAR:
                begin
                    // match clears the counter
                    if (count_r == cmp_a_r) count_nxt = `TWOC_BOTTOM;
                    else count_nxt = count_r + 8'h01;
                    ovf_evt = (count_r == `TWOC_MAX);
                end
                `TWOC_MODE_SINGLE_FF, `TWOC_MODE_SINGLE_CA:
                begin
                    if (count_r == top)
                    begin
                        count_nxt = `TWOC_BOTTOM;
                        at_top = 1'b1;
                    end
                    else
                        count_nxt = count_r + 8'h01;
                    if (mode == `TWOC_MODE_SINGLE_CA) ovf_evt = at_top;
                    else ovf_evt = (count_r == `TWOC_MAX);
                end
                `TWOC_MODE_DUAL_FF, `TWOC_MODE_DUAL_CA:
                begin
                    // TOP is held for exactly one tick, then count down
                    if (up_r && count_r >= top)
                    begin
                        up_nxt = 1'b0;
                        at_top = 1'b1;
                        count_nxt = (count_r == `TWOC_BOTTOM) ? count_r : count_r - 8'h01;
                    end
                    else if (up_r)
                        count_nxt = count_r + 8'h01;
                    else if (count_r == `TWOC_BOTTOM)
                    begin
                        up_nxt = 1'b1;
                        ovf_evt = 1'b1;
                        count_nxt = count_r + 8'h01;
                    end
                    else
                        count_nxt = count_r - 8'h01;
                end
                default:
                begin
                    // normal and reserved codes free-run to MAX
                    count_nxt = count_r + 8'h01;
                    ovf_evt = (count_r == `TWOC_MAX);
                end
            endcase
        end
    end

    assign addr_ok = (wr_addr_r == `TWOC_ADDR_CTRL_A) || (wr_addr_r == `TWOC_ADDR_CTRL_B)
        || (wr_addr_r == `TWOC_ADDR_COUNT) || (wr_addr_r == `TWOC_ADDR_CMP_A)
        || (wr_addr_r == `TWOC_ADDR_CMP_B) || (wr_addr_r == `TWOC_ADDR_FLAGS);
    assign wr = wr_pend_r & addr_ok;
    assign flag_wr = wr & (wr_addr_r == `TWOC_ADDR_FLAGS);

    // zero-wait-state slave, always OKAY
    always @(posedge CLK)
    begin
        if (!RSTN)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            HRDATA <= 32'h00000000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
        else
        begin
            wr_pend_r <= HSEL & HREADY & HTRANS[1] & HWRITE;
            wr_addr_r <= {HADDR[7:2], 2'b00};
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            if (HSEL && HREADY && HTRANS[1] && !HWRITE)
            begin
                case ({HADDR[7:2], 2'b00})
                    `TWOC_ADDR_CTRL_A: HRDATA <= {24'h000000, ctrl_a_r & `TWOC_CTRL_A_WMASK};
                    `TWOC_ADDR_CTRL_B: HRDATA <= {28'h0000000, sel_high_r, 2'b00, run_r};
                    `TWOC_ADDR_COUNT: HRDATA <= {24'h000000, count_r};
                    `TWOC_ADDR_CMP_A: HRDATA <= {24'h000000, cmp_a_buf_r};
                    `TWOC_ADDR_CMP_B: HRDATA <= {24'h000000, cmp_b_buf_r};
                    `TWOC_ADDR_FLAGS: HRDATA <= {29'h00000000, flag_b_r, flag_a_r, ovf_r};
                    default: HRDATA <= 32'h00000000;
                endcase
            end
        end
    end

    always @(posedge CLK)
    begin
        if (!RSTN)
        begin
            ctrl_a_r <= `TWOC_RESET_BYTE;
            sel_high_r <= 1'b0;
            run_r <= 1'b0;
            count_r <= `TWOC_RESET_BYTE;
            up_r <= 1'b1;
            cmp_a_buf_r <= `TWOC_RESET_BYTE;
            cmp_b_buf_r <= `TWOC_RESET_BYTE;
            cmp_a_r <= `TWOC_RESET_BYTE;
            cmp_b_r <= `TWOC_RESET_BYTE;
            ovf_r <= 1'b0;
            flag_a_r <= 1'b0;
            flag_b_r <= 1'b0;
            cnt_written_r <= 1'b0;
        end
        else
        begin
            if (wr && wr_addr_r == `TWOC_ADDR_CTRL_A)
                ctrl_a_r <= HWDATA[7:0] & `TWOC_CTRL_A_WMASK;
            if (wr && wr_addr_r == `TWOC_ADDR_CTRL_B)
            begin
                sel_high_r <= HWDATA[`TWOC_CTRL_B_SEL_HIGH];
                run_r <= HWDATA[`TWOC_CTRL_B_RUN];
            end
            if (wr && wr_addr_r == `TWOC_ADDR_CMP_A) cmp_a_buf_r <= HWDATA[7:0];
            if (wr && wr_addr_r == `TWOC_ADDR_CMP_B) cmp_b_buf_r <= HWDATA[7:0];
            // PWM loads the live compare only at TOP to avoid glitched pulses
            if (!is_pwm || at_top)
            begin
                cmp_a_r <= (wr && wr_addr_r == `TWOC_ADDR_CMP_A) ? HWDATA[7:0] : cmp_a_buf_r;
                cmp_b_r <= (wr && wr_addr_r == `TWOC_ADDR_CMP_B) ? HWDATA[7:0] : cmp_b_buf_r;
            end
            if (wr && wr_addr_r == `TWOC_ADDR_COUNT)
            begin
                count_r <= HWDATA[7:0];
                cnt_written_r <= 1'b1;
            end
            else
            begin
                count_r <= count_nxt;
                up_r <= up_nxt;
                if (tick) cnt_written_r <= 1'b0;
            end
            // write one clears; a same-cycle event wins
            ovf_r <= ovf_evt | (ovf_r & ~(flag_wr & HWDATA[`TWOC_FLAG_OVF]));
            flag_a_r <= match_a | (flag_a_r & ~(flag_wr & HWDATA[`TWOC_FLAG_CMP_A]));
            flag_b_r <= match_b | (flag_b_r & ~(flag_wr & HWDATA[`TWOC_FLAG_CMP_B]));
        end
    end

    twoc_wave_chan #(.TOGGLE_IN_PWM(1)) u_chan_a (
        .clk(CLK),
        .rstn(RSTN),
        .out_mode(ctrl_a_r[`TWOC_CTRL_A_MODE_A_HI:`TWOC_CTRL_A_MODE_A_LO]),
        .sel_high(sel_high_r),
        .is_pwm(is_pwm),
        .is_dual(is_dual),
        .match(match_a),
        .at_top(at_top),
        .counting_up(up_r),
        .cmp_is_top(cmp_a_r == top),
        .wave_r(wave_a),
        .connect_r(con_a)
    );

    twoc_wave_chan #(.TOGGLE_IN_PWM(0)) u_chan_b (
        .clk(CLK),
        .rstn(RSTN),
        .out_mode(ctrl_a_r[`TWOC_CTRL_A_MODE_B_HI:`TWOC_CTRL_A_MODE_B_LO]),
        .sel_high(sel_high_r),
        .is_pwm(is_pwm),
        .is_dual(is_dual),
        .match(match_b),
        .at_top(at_top),
        .counting_up(up_r),
        .cmp_is_top(cmp_b_r == top),
        .wave_r(wave_b),
        .connect_r(con_b)
    );

    // pin driver still needs the port direction bit, kept outside
    always @(posedge CLK)
    begin
        if (!RSTN)
        begin
            WAVE_OUT_A <= 1'b0;
            WAVE_OUT_B <= 1'b0;
            WAVE_EN_A <= 1'b0;
            WAVE_EN_B <= 1'b0;
        end
        else
        begin
            WAVE_OUT_A <= wave_a;
            WAVE_OUT_B <= wave_b;
            WAVE_EN_A <= con_a;
            WAVE_EN_B <= con_b;
        end
    end
endmodule // twoc_timer_wave

// ### pkg/twoc_consts.vh
/*
 * Constants for the timer waveform output control block: register byte
 * addresses, field positions, reset values, mode codes and limits.
 * Assumes a 32-bit AHB-Lite slave with one register per aligned word.
 */
`ifndef TWOC_CONSTS_VH
`define TWOC_CONSTS_VH
`define TWOC_ADDR_CTRL_A 8'h00
`define TWOC_ADDR_CTRL_B 8'h04
`define TWOC_ADDR_COUNT 8'h08
`define TWOC_ADDR_CMP_A 8'h0C
`define TWOC_ADDR_CMP_B 8'h10
`define TWOC_ADDR_FLAGS 8'h14
`define TWOC_CTRL_A_MODE_A_HI 7
`define TWOC_CTRL_A_MODE_A_LO 6
`define TWOC_CTRL_A_MODE_B_HI 5
`define TWOC_CTRL_A_MODE_B_LO 4
`define TWOC_CTRL_A_WMASK 8'hF3
`define TWOC_CTRL_B_SEL_HIGH 3
`define TWOC_CTRL_B_RUN 0
`define TWOC_FLAG_OVF 0
`define TWOC_FLAG_CMP_A 1
`define TWOC_FLAG_CMP_B 2
`define TWOC_RESET_BYTE 8'h00
`define TWOC_MAX 8'hFF
`define TWOC_BOTTOM 8'h00
`define TWOC_MODE_NORMAL 3'h0
`define TWOC_MODE_DUAL_FF 3'h1
`define TWOC_MODE_CLEAR 3'h2
`define TWOC_MODE_SINGLE_FF 3'h3
`define TWOC_MODE_DUAL_CA 3'h5
`define TWOC_MODE_SINGLE_CA 3'h7
`define TWOC_OM_OFF 2'h0
`define TWOC_OM_TOGGLE 2'h1
`define TWOC_OM_CLEAR 2'h2
`define TWOC_OM_SET 2'h3
`endif

// ### hw/twoc_wave_chan.v
/*
 * One compare output channel: decides the next wave level from the
 * output-mode code, the waveform type and the match and TOP events.
 * Assumes events arrive as one-cycle pulses already gated by the tick.
 */
`include "twoc_consts.vh"
module twoc_wave_chan #(
    parameter TOGGLE_IN_PWM = 1
) (
    input wire clk,
    input wire rstn,
    input wire [1:0] out_mode,
    input wire sel_high,
    input wire is_pwm,
    input wire is_dual,
    input wire match,
    input wire at_top,
    input wire counting_up,
    input wire cmp_is_top,
    output reg wave_r,
    output reg connect_r
);
    reg wave_nxt;
    reg connect_nxt;
    reg hit;

    always @*
    begin
        wave_nxt = wave_r;
        connect_nxt = (out_mode != `TWOC_OM_OFF);
        // compare at TOP: the match is dropped, the TOP action remains
        hit = match & ~(is_pwm & out_mode[1] & cmp_is_top);
        if (!is_pwm)
        begin
            case (out_mode)
                `TWOC_OM_TOGGLE: if (hit) wave_nxt = ~wave_r;
                `TWOC_OM_CLEAR: if (hit) wave_nxt = 1'b0;
                `TWOC_OM_SET: if (hit) wave_nxt = 1'b1;
                default: wave_nxt = wave_r;
            endcase
        end
        else
        begin
            case (out_mode)
                `TWOC_OM_TOGGLE:
                begin
                    // channel B code 1 is reserved: left with the port
                    if (TOGGLE_IN_PWM != 0 && sel_high)
                    begin
                        if (hit) wave_nxt = ~wave_r;
                    end
                    else
                        connect_nxt = 1'b0;
                end
                `TWOC_OM_CLEAR:
                begin
                    if (is_dual)
                    begin
                        if (hit) wave_nxt = ~counting_up;
                        if (cmp_is_top && at_top) wave_nxt = 1'b1;
                    end
                    else
                    begin
                        if (hit) wave_nxt = 1'b0;
                        if (at_top) wave_nxt = 1'b1;
                    end
                end
                `TWOC_OM_SET:
                begin
                    if (is_dual)
                    begin
                        if (hit) wave_nxt = counting_up;
                        if (cmp_is_top && at_top) wave_nxt = 1'b0;
                    end
                    else
                    begin
                        if (hit) wave_nxt = 1'b1;
                        if (at_top) wave_nxt = 1'b0;
                    end
                end
                default: wave_nxt = wave_r;
            endcase
        end
    end

    always @(posedge clk)
    begin
        if (!rstn)
        begin
            wave_r <= 1'b0;
            connect_r <= 1'b0;
        end
        else
        begin
            wave_r <= wave_nxt;
            connect_r <= connect_nxt;
        end
    end
endmodule // twoc_wave_chan

// ### verif/twoc_timer_wave_monitor.sv
/* checker for the timer wave block: bus answers and pin ownership.
   assumes one AHB-Lite master with hready looped from HREADYOUT. */
`include "twoc_consts.vh"
module twoc_timer_wave_monitor (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic TICK_EN,
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic WAVE_OUT_A,
    input wire logic WAVE_EN_A,
    input wire logic WAVE_EN_B
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    logic ap_v_r;
    logic ap_w_r;
    logic [7:0] ap_a_r;
    logic [7:0] ctl_r;
    logic hi_r;
    logic [1:0] quiet_r;
    logic pwm;
    logic en_a_exp;
    logic en_b_exp;
    // modes 1,3,5,7 are the pwm ones
    assign pwm = ctl_r[0];
    assign en_a_exp = |ctl_r[7:6] && !(pwm && ctl_r[7:6] == 2'h1 && !hi_r);
    assign en_b_exp = |ctl_r[5:4] && !(pwm && ctl_r[5:4] == 2'h1);
    always @(posedge CLK)
    begin
        if (!RSTN)
        begin
            ap_v_r <= 1'b0;
            ap_w_r <= 1'b0;
            ap_a_r <= 8'h00;
            ctl_r <= 8'h00;
            hi_r <= 1'b0;
            quiet_r <= 2'h0;
        end
        else
        begin
            ap_v_r <= HSEL && HREADY && HTRANS[1];
            ap_w_r <= HWRITE;
            ap_a_r <= HADDR;
            if (ap_v_r && ap_w_r && ap_a_r == `TWOC_ADDR_CTRL_A)
                ctl_r <= HWDATA[7:0];
            if (ap_v_r && ap_w_r && ap_a_r == `TWOC_ADDR_CTRL_B)
                hi_r <= HWDATA[`TWOC_CTRL_B_SEL_HIGH];
            // pin ownership may lag a control write by a few edges
            quiet_r <= (ap_v_r && ap_w_r) ? 2'h0 : (quiet_r == 2'h3 ? 2'h3 : quiet_r + 2'h1);
        end
    end
    sequence rd_s(a);
        ap_v_r && !ap_w_r && ap_a_r == a;
    endsequence
    sequence any_rd_s;
        ap_v_r && !ap_w_r;
    endsequence
    ready_always_a: assert property (HREADYOUT) else $error("hreadyout low");
    resp_okay_a: assert property (!HRESP) else $error("error response");
    resv_zero_a: assert property (rd_s(`TWOC_ADDR_CTRL_A) |-> HRDATA[3:2] == 2'h0)
        else $error("reserved control bits not zero");
    field_map_a: assert property (rd_s(`TWOC_ADDR_CTRL_A) |->
        HRDATA[7:0] == ($past(ctl_r) & `TWOC_CTRL_A_WMASK)) else $error("control field moved");
    upper_zero_a: assert property (any_rd_s |-> HRDATA[31:8] == 24'h0)
        else $error("upper read bits not zero");
    unmapped_zero_a: assert property (any_rd_s ##0 (ap_a_r > `TWOC_ADDR_FLAGS) |-> HRDATA == 32'h0)
        else $error("unmapped read not zero");
    conn_a_a: assert property (quiet_r == 2'h3 |-> WAVE_EN_A == en_a_exp)
        else $error("channel a pin ownership wrong");
    conn_b_a: assert property (quiet_r == 2'h3 |-> WAVE_EN_B == en_b_exp)
        else $error("channel b pin ownership wrong");
    wave_tick_a: assert property ($changed(WAVE_OUT_A) && quiet_r == 2'h3 |->
        $past(TICK_EN, 2) || $past(TICK_EN, 3) || $past(TICK_EN, 4))
        else $error("wave a moved without a tick");
endmodule // twoc_timer_wave_monitor
bind twoc_timer_wave twoc_timer_wave_monitor twoc_timer_wave_monitor_i (.CLK(CLK), .RSTN(RSTN),
    .TICK_EN(TICK_EN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .WAVE_OUT_A(WAVE_OUT_A), .WAVE_EN_A(WAVE_EN_A), .WAVE_EN_B(WAVE_EN_B));

// ### verif/tb.sv
/* self-checking bench for the timer wave block.
   assumes a zero-wait slave; the tick enable comes from this bench. */
`include "twoc_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0;
    logic RSTN = 1'b0;
    logic TICK_EN = 1'b0;
    logic tick_on = 1'b1;
    logic HSEL = 1'b0;
    logic HWRITE = 1'b0;
    logic [7:0] HADDR = 8'h00;
    logic [1:0] HTRANS = 2'h0;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HWDATA = 32'h0;
    logic [31:0] HRDATA;
    logic [31:0] rd;
    logic HREADYOUT, HRESP, WAVE_OUT_A, WAVE_OUT_B, WAVE_EN_A, WAVE_EN_B;
    int n_mismatch = 0;
    int n_tests = 0;
    twoc_timer_wave twoc_timer_wave_i (.CLK(CLK), .RSTN(RSTN), .TICK_EN(TICK_EN), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .WAVE_OUT_A(WAVE_OUT_A), .WAVE_OUT_B(WAVE_OUT_B), .WAVE_EN_A(WAVE_EN_A),
        .WAVE_EN_B(WAVE_EN_B));
    initial forever #12.5 CLK = ~CLK;
    always @(posedge CLK) TICK_EN <= tick_on;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= a;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        @(posedge CLK);
        while (HREADYOUT !== 1'b1) @(posedge CLK);
        rd = HRDATA;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // compares are loaded while the mode is non-pwm, so they land at once
    task automatic setup(input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] pa,
        input logic [7:0] pb);
        wr(`TWOC_ADDR_CTRL_B, 32'h0);
        wr(`TWOC_ADDR_CTRL_A, 32'h0);
        wr(`TWOC_ADDR_COUNT, 32'h0);
        wr(`TWOC_ADDR_CMP_A, {24'h0, pa});
        wr(`TWOC_ADDR_CMP_B, {24'h0, pb});
        wr(`TWOC_ADDR_CTRL_A, {24'h0, ca});
        wr(`TWOC_ADDR_CTRL_B, {24'h0, cb});
        wr(`TWOC_ADDR_FLAGS, 32'h7);
        repeat (40) @(posedge CLK);
    endtask
    task automatic hi_cnt(input int n, output int ha, output int hb);
        ha = 0;
        hb = 0;
        repeat (n)
        begin
            @(posedge CLK);
            ha += int'(WAVE_OUT_A === 1'b1);
            hb += int'(WAVE_OUT_B === 1'b1);
        end
    endtask
    task automatic t_regs;
        for (int i = 0; i < 7; i++)
            rdc("reset_value", 8'(i * 4), 32'h0);
        wr(`TWOC_ADDR_CTRL_A, 32'hFF);
        rdc("ctrl_a", `TWOC_ADDR_CTRL_A, 32'hF3);
        wr(8'h18, 32'hFF);
        rdc("unmapped", 8'h18, 32'h0);
    endtask
    task automatic t_tick;
        setup(8'h00, 8'h01, 8'h00, 8'h00);
        tick_on <= 1'b0;
        wr(`TWOC_ADDR_COUNT, 32'h20);
        repeat (6) @(posedge CLK);
        rdc("held_count", `TWOC_ADDR_COUNT, 32'h20);
        wr(`TWOC_ADDR_COUNT, 32'hFD);
        wr(`TWOC_ADDR_FLAGS, 32'h7);
        tick_on <= 1'b1;
        repeat (8) @(posedge CLK);
        bus(1'b0, `TWOC_ADDR_FLAGS, 32'h0);
        chk("ovf_max", 32'h1, {31'h0, rd[`TWOC_FLAG_OVF]});
    endtask
    task automatic t_ctc;
        logic w;
        setup(8'h42, 8'h01, 8'h03, 8'h00);
        bus(1'b0, `TWOC_ADDR_COUNT, 32'h0);
        chk("ctc_count", 32'h1, {31'h0, rd < 32'h4});
        bus(1'b0, `TWOC_ADDR_FLAGS, 32'h0);
        chk("cmp_flag", 32'h1, {31'h0, rd[`TWOC_FLAG_CMP_A]});
        wr(`TWOC_ADDR_CMP_A, 32'h5);
        repeat (10) @(posedge CLK);
        w = WAVE_OUT_A;
        repeat (6) @(posedge CLK);
        chk("toggle", {31'h0, ~w}, {31'h0, WAVE_OUT_A});
    endtask
    task automatic t_codes;
        logic [1:0] m;
        for (int c = 0; c < 4; c++)
        begin
            m = 2'(c);
            setup({m, m, 4'h2}, 8'h01, 8'h03, 8'h01);
            chk("en_a", {31'h0, m != 2'h0}, {31'h0, WAVE_EN_A});
            chk("en_b", {31'h0, m != 2'h0}, {31'h0, WAVE_EN_B});
            if (m[1])
            begin
                chk("out_a", {31'h0, m[0]}, {31'h0, WAVE_OUT_A});
                chk("out_b", {31'h0, m[0]}, {31'h0, WAVE_OUT_B});
            end
        end
    endtask
    task automatic t_pwm;
        logic [1:0] m;
        int ha, hb;
        for (int c = 2; c < 4; c++)
        begin
            m = 2'(c);
            setup({m, m, 4'h3}, 8'h09, 8'h09, 8'h02);
            hi_cnt(10, ha, hb);
            chk("fast_a", m[0] ? 32'd0 : 32'd10, 32'(ha));
            chk("fast_b", m[0] ? 32'd7 : 32'd3, 32'(hb));
            wr(`TWOC_ADDR_FLAGS, 32'h7);
            repeat (12) @(posedge CLK);
            bus(1'b0, `TWOC_ADDR_FLAGS, 32'h0);
            chk("ovf_top", 32'h1, {31'h0, rd[`TWOC_FLAG_OVF]});
            setup({m, m, 4'h1}, 8'h09, 8'h09, 8'h03);
            hi_cnt(18, ha, hb);
            chk("dual_a", m[0] ? 32'd0 : 32'd18, 32'(ha));
            chk("dual_b", m[0] ? 32'd12 : 32'd6, 32'(hb));
            wr(`TWOC_ADDR_FLAGS, 32'h7);
            repeat (20) @(posedge CLK);
            bus(1'b0, `TWOC_ADDR_FLAGS, 32'h0);
            chk("ovf_bottom", 32'h1, {31'h0, rd[`TWOC_FLAG_OVF]});
        end
        // pin direction stays with the port; only ownership is seen here
        setup(8'h53, 8'h09, 8'h09, 8'h02);
        chk("en_a_hi", 32'h1, {31'h0, WAVE_EN_A});
        chk("en_b_rsv", 32'h0, {31'h0, WAVE_EN_B});
        setup(8'h53, 8'h01, 8'h09, 8'h02);
        chk("en_a_lo", 32'h0, {31'h0, WAVE_EN_A});
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge CLK);
        RSTN <= 1'b1;
        @(posedge CLK);
        t_regs();
        t_tick();
        t_ctc();
        t_codes();
        t_pwm();
        close_out();
    end
    // the tests need about 900 cycles
    initial
    begin
        repeat (20000) @(posedge CLK);
        n_mismatch++;
        close_out();
    end
endmodule // tb
